/* File: dv/sdp_monitor.sv */
// Purpose: port assertions for the speed and direction pulse core
// Assumes: one clock domain, synchronous reset
// Notes: seen_ff marks that a pulse was sent since the last reset
`timescale 1ns/1ps
module sdp_monitor (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic signed [11:0] speed_i,
   input wire sdp_pkg::supply_t supply_i,
   input wire sdp_pkg::out_t out_o,
   input wire logic calibrated_o
);
   logic seen_ff;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || supply_i.brownout) seen_ff <= 1'b0;
      else if (out_o.pulse) seen_ff <= 1'b1;
   end
   ////////////////////////////////
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i || supply_i.brownout);
   sequence pulse_start;
      $rose(out_o.pulse);
   endsequence
   // Edge sample sits two cycles before the pulse rises
   sequence big_step(int t);
      $past(speed_i, 2) > t || $past(speed_i, 2) < -t;
   endsequence
   chk_reset_clear: assert property (disable iff (1'b0) rst_i |=> out_o == '0 && !calibrated_o)
      else $error("outputs not cleared by reset");
   chk_brownout_clear: assert property (disable iff (rst_i) supply_i.brownout |=> out_o == '0 && !calibrated_o)
      else $error("outputs not cleared by brownout");
   chk_pulse_len: assert property (pulse_start |-> out_o.pulse [*8])
      else $error("pulse shorter than eight cycles");
   chk_first_speed_only: assert property (pulse_start ##0 !seen_ff |-> !out_o.dir_valid)
      else $error("first pulse carries direction");
   chk_later_dir: assert property (pulse_start ##0 seen_ff |-> out_o.dir_valid)
      else $error("later pulse without direction");
   chk_hyst_floor: assert property (pulse_start |-> big_step(16))
      else $error("pulse from sample inside minimum hysteresis");
   chk_noise_thr: assert property (pulse_start ##0 !$past(calibrated_o, 2) |-> big_step(32))
      else $error("uncalibrated pulse below noise threshold");
   chk_force_cause: assert property (out_o.force_high |-> $past(supply_i.under_range))
      else $error("high current without undervoltage");
   chk_force_armed: assert property (seen_ff && supply_i.under_range |=> out_o.force_high)
      else $error("undervoltage not answered once armed");
   chk_cal_hold: assert property ($fell(calibrated_o) |-> $past(rst_i) || $past(supply_i.brownout))
      else $error("calibrated mode left without reset");
endmodule
bind speed_direction_pulse_core sdp_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .speed_i(speed_i), .supply_i(supply_i), .out_o(out_o), .calibrated_o(calibrated_o));

/* File: dv/tb_speed_direction_pulse_core.sv */
// Purpose: self-checking bench of the pulse core
// Assumes: outer probes tied equal, so direction follows the center probe
// Notes: each half period of the wheel lasts 12 cycles
`timescale 1ns/1ps
module tb_speed_direction_pulse_core;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic signed [11:0] speed = '0;
   logic signed [11:0] hc = '0;
   logic offset_done = 1'b0;
   sdp_pkg::supply_t supply = '0;
   sdp_pkg::out_t out;
   logic cal, dv, dr;
   int pulses, p0;
   int fail_count = 0;
   int checks_done = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   speed_direction_pulse_core DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .speed_i(speed),
      .hall_left_i(12'sh000), .hall_right_i(12'sh000), .hall_center_i(hc),
      .offset_done_i(offset_done), .supply_i(supply), .out_o(out), .calibrated_o(cal));
   tcu_model tcu (.ref_clk_i(ref_clk_i), .out_i(out), .pulses_o(pulses), .dir_valid_o(dv),
      .dir_rev_o(dr));
   ////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #2;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   // Center probe with the same sign as the speed edge means forward
   task automatic swing(input logic signed [11:0] a, input int halves, input logic rev);
      for (int i = 0; i < halves; i++) begin
         speed = i[0] ? -a : a;
         hc = (i[0] ^ rev) ? -a : a;
         step(12);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////
   task automatic t_startup;
      swing(12'sh018, 4, 1'b0);
      check(pulses, 0);
      swing(12'sh100, 1, 1'b0);
      check(pulses, 1);
      check(dv, 1'b0);
      swing(12'sh100, 3, 1'b0);
      check(dv, 1'b1);
      check(cal, 1'b1);
   endtask
   task automatic t_direction;
      swing(12'sh100, 2, 1'b0);
      check(dr, 1'b0);
      swing(12'sh100, 2, 1'b1);
      check(dr, 1'b1);
   endtask
   task automatic t_vibration;
      swing(12'sh030, 4, 1'b1);
      p0 = pulses;
      swing(12'sh030, 4, 1'b0);
      // Only the first flipped edge is vibration; the next ones agree with it
      check(pulses, p0 + 3);
   endtask
   task automatic t_supply;
      supply.under_range = 1'b1;
      step(3);
      check(out.force_high, 1'b1);
      supply.under_range = 1'b0;
      step(2);
      check(out.force_high, 1'b0);
      supply.brownout = 1'b1;
      step(1);
      supply.brownout = 1'b0;
      step(1);
      check(cal, 1'b0);
      swing(12'sh100, 1, 1'b0);
      check(dv, 1'b0);
      offset_done = 1'b1;
      step(1);
      offset_done = 1'b0;
      step(2);
      check(cal, 1'b1);
   endtask
   initial begin
      step(6);
      rst_i = 1'b0;
      step(1);
      t_startup();
      t_direction();
      t_vibration();
      t_supply();
      tally_and_finish();
   end
   initial begin
      #100us;
      fail_count++;
      tally_and_finish();
   end
endmodule

/* File: dv/tcu_model.sv */
// Purpose: control unit that reads output pulses
// Assumes: a pulse is one rise of the pulse line
// Notes: keeps a running count; the bench compares differences
`timescale 1ns/1ps
module tcu_model (
   input wire logic ref_clk_i,
   input wire sdp_pkg::out_t out_i,
   output int pulses_o,
   output logic dir_valid_o,
   output logic dir_rev_o
);
   logic prev_ff = 1'b0;
   initial pulses_o = 0;
   ////////////////////////////////
   always @(posedge ref_clk_i) begin
      prev_ff <= out_i.pulse;
      if (out_i.pulse && !prev_ff) begin
         pulses_o <= pulses_o + 1;
         dir_valid_o <= out_i.dir_valid;
         dir_rev_o <= out_i.dir_rev;
      end
   end
endmodule

/* File: verilog/amp_tracker.sv */
// Purpose: peak tracking of the speed signal and amplitude estimate
// Assumes: samples arrive every clock; extrema latched at each zero crossing
// Notes: amplitude is half the last peak to peak span
`timescale 1ns/1ps
module amp_tracker #(
   parameter int W = sdp_pkg::SAMPLE_W
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Speed sample and zero crossing marker
   input wire logic signed [W-1:0] speed_i,
   input wire logic zc_i,
   // Amplitude estimate
   output logic [W-1:0] amp_o
);

   typedef struct packed {
      logic signed [W-1:0] max;
      logic signed [W-1:0] min;
      logic [W-1:0] amp;
   } st_t;

   st_t st_ff;
   st_t nxt_st;
   logic signed [W:0] span;
   logic signed [W-1:0] hi;
   logic signed [W-1:0] lo;

   always_comb begin
      nxt_st = st_ff;
      // The crossing sample belongs to the span, else a flat half period reads as zero
      hi = (speed_i > st_ff.max) ? speed_i : st_ff.max;
      lo = (speed_i < st_ff.min) ? speed_i : st_ff.min;
      span = $signed({hi[W-1], hi}) - $signed({lo[W-1], lo});
      nxt_st.max = hi;
      nxt_st.min = lo;
      if (zc_i) begin
         // Restart peak search each half period so the estimate follows the signal
         nxt_st.amp = span[W:1];
         nxt_st.max = speed_i;
         nxt_st.min = speed_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign amp_o = st_ff.amp;

endmodule

/* File: verilog/sdp_pkg.sv */
// Purpose: shared constants and types of the speed and direction pulse core
// Assumes: signed two's complement samples from the speed and direction converters
// Notes: amplitude values are in converter codes
package sdp_pkg;

   localparam int SAMPLE_W = 12;
   // Minimum speed amplitude in converter codes (floor of the hysteresis)
   localparam logic [SAMPLE_W-1:0] SPEED_LIMIT_RST = 12'h010;
   // Hysteresis is amplitude >> HYST_SHIFT, i.e. one eighth
   localparam int HYST_SHIFT = 3;
   // Noise threshold start value is twice the minimum amplitude
   localparam int NOISE_SHIFT = 1;
   // Start-up pulses before calibration is taken as done
   localparam logic [2:0] CAL_EDGES = 3'h3;
   // Length of an output pulse in clock cycles
   localparam logic [3:0] PULSE_LEN = 4'h8;

   typedef logic signed [SAMPLE_W-1:0] sample_t;

   typedef enum logic [1:0] {
      DIR_NONE,
      DIR_FWD,
      DIR_REV
   } dir_t;

   typedef struct packed {
      logic pulse;
      logic dir_valid;
      logic dir_rev;
      logic force_high;
   } out_t;

   typedef struct packed {
      logic under_range;
      logic brownout;
   } supply_t;

endpackage

/* File: verilog/speed_direction_pulse_core.sv */
// Purpose: digital core of a differential speed and direction sensor
// Assumes: speed and direction samples are synchronous converter outputs
// Notes: supply monitor flags come from analog comparators, already synchronous
// Behaviour
// - Hysteresis is one eighth of amplitude
// - Hysteresis never below minimum speed amplitude
// - Excursions inside hysteresis cause no switching
// - Direction is center minus mean of outer
// - Center lead or lag sets direction
// - Sample direction at speed zero crossings
// - First pulse after power-on is speed only
// - Amplitude and direction classify vibration edges
// - Vibration edges produce no output pulse
// - Hysteresis suppression active from power-on
// - Direction suppression only once calibrated
// - Undervoltage detection armed after first switching
// - Undervoltage forces high current until recovery
// - Brownout resets core and restarts calibration
// - Calibrated mode switches at adaptive hysteresis
// - Uncalibrated uses noise threshold, floor twice minimum
`timescale 1ns/1ps
module speed_direction_pulse_core #(
   parameter int W = sdp_pkg::SAMPLE_W,
   parameter logic [W-1:0] SPEED_LIMIT = sdp_pkg::SPEED_LIMIT_RST
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Converter samples
   input wire logic signed [W-1:0] speed_i,
   input wire logic signed [W-1:0] hall_left_i,
   input wire logic signed [W-1:0] hall_right_i,
   input wire logic signed [W-1:0] hall_center_i,
   // Offset correction done strobe from the offset loop
   input wire logic offset_done_i,
   // Supply monitor
   input wire sdp_pkg::supply_t supply_i,
   // Output towards the current driver
   output sdp_pkg::out_t out_o,
   output logic calibrated_o
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic speed_pos;
      logic calibrated;
      logic [2:0] edges;
      logic [W-1:0] noise_trigger_threshold;
      sdp_pkg::dir_t dir;
      sdp_pkg::dir_t last_dir;
      logic uv_armed;
      logic pulsing;
      logic [3:0] pulse_cnt;
      sdp_pkg::out_t out;
   } st_t;

   st_t st_ff;
   st_t nxt_st;

   logic [W-1:0] amp;
   logic [W-1:0] hyst;
   logic [W-1:0] thr;
   logic signed [W+1:0] dir_sig;
   logic zc;
   logic rise;
   logic fall;
   logic vib;
   sdp_pkg::dir_t dir_now;

   ////////////////////////////////////////////////////////////////////////
   // Amplitude tracking
   amp_tracker #(
      .W(W)
   ) u_amp (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i || supply_i.brownout),
      .speed_i(speed_i),
      .zc_i(zc),
      .amp_o(amp)
   );

   ////////////////////////////////////////////////////////////////////////
   // Thresholds and edges
   always_comb begin
      hyst = amp >> sdp_pkg::HYST_SHIFT;
      if (hyst < SPEED_LIMIT) begin
         hyst = SPEED_LIMIT;
      end
      // Calibrated switches on hysteresis, otherwise on noise threshold
      thr = st_ff.calibrated ? hyst : st_ff.noise_trigger_threshold;
      // Switch only when the excursion passes the threshold on the far side
      rise = !st_ff.speed_pos && (speed_i > $signed(thr));
      fall = st_ff.speed_pos && (speed_i < -$signed(thr));
      zc = rise || fall;
      // Center minus mean of outer, scaled by two to stay integer
      dir_sig = ($signed({{2{hall_center_i[W-1]}}, hall_center_i}) <<< 1)
         - $signed({{2{hall_left_i[W-1]}}, hall_left_i})
         - $signed({{2{hall_right_i[W-1]}}, hall_right_i});
      // Center high on a rising speed edge means it leads by a quarter period
      if (dir_sig[W+1] == rise) begin
         dir_now = sdp_pkg::DIR_REV;
      end else begin
         dir_now = sdp_pkg::DIR_FWD;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Vibration classification
   // A direction flip on a small signal is taken as vibration, not reversal
   assign vib = st_ff.calibrated && (st_ff.last_dir != sdp_pkg::DIR_NONE)
      && (dir_now != st_ff.last_dir) && (amp < (hyst << 2));

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.out.pulse = 1'b0;
      if (offset_done_i && st_ff.edges != '0) begin
         nxt_st.calibrated = 1'b1;
      end
      if (st_ff.edges == sdp_pkg::CAL_EDGES) begin
         nxt_st.calibrated = 1'b1;
      end
      if (!st_ff.calibrated && zc) begin
         // Half the amplitude, so a steady signal still crosses it; start value is the floor
         if ((amp >> sdp_pkg::NOISE_SHIFT) > (SPEED_LIMIT << sdp_pkg::NOISE_SHIFT)) begin
            nxt_st.noise_trigger_threshold = amp >> sdp_pkg::NOISE_SHIFT;
         end else begin
            nxt_st.noise_trigger_threshold = SPEED_LIMIT << sdp_pkg::NOISE_SHIFT;
         end
      end
      if (zc) begin
         nxt_st.speed_pos = rise;
         nxt_st.last_dir = dir_now;
         if (!vib) begin
            nxt_st.dir = dir_now;
            nxt_st.pulsing = 1'b1;
            nxt_st.pulse_cnt = sdp_pkg::PULSE_LEN;
            nxt_st.out.dir_valid = (st_ff.edges != '0);
            nxt_st.out.dir_rev = (dir_now == sdp_pkg::DIR_REV) && (st_ff.edges != '0);
            if (st_ff.edges != sdp_pkg::CAL_EDGES) begin
               nxt_st.edges = st_ff.edges + 3'h1;
            end
            nxt_st.uv_armed = 1'b1;
         end // Vibration edge: no pulse
      end
      if (st_ff.pulsing) begin
         nxt_st.out.pulse = 1'b1;
         nxt_st.pulse_cnt = st_ff.pulse_cnt - 4'h1;
         if (st_ff.pulse_cnt == 4'h1) begin
            nxt_st.pulsing = 1'b0;
         end
      end
      nxt_st.out.force_high = st_ff.uv_armed && supply_i.under_range;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || supply_i.brownout) begin
         st_ff <= '0;
         st_ff.noise_trigger_threshold <= SPEED_LIMIT << sdp_pkg::NOISE_SHIFT;
         st_ff.dir <= sdp_pkg::DIR_NONE;
         st_ff.last_dir <= sdp_pkg::DIR_NONE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign out_o = st_ff.out;
   assign calibrated_o = st_ff.calibrated;

endmodule
